// file: tms_pkg.sv
// train movement supervision: shared constants and types
// assumes odometry delivers one pulse per fixed travel step with a direction
package tms_pkg;

    // distance thresholds in centimetres, as specified
    localparam int ROLL_AWAY_STILL_CM = 2000; // creep under standstill, 20 m
    localparam int TRAVEL_LIMIT_CM = 500; // all other checks, 5 m

    // default odometry step length in centimetres (plain default)
    localparam int ODO_STEP_CM_DEF = 10;

    // default distance counter width
    localparam int CNT_W_DEF = 12;

    // operating mode code width and number of codes
    localparam int MODE_W = 3;
    localparam int MODE_N = 8;

    // default mode applicability masks, one bit per mode code, and the reverse shunting mode code (plain defaults)
    localparam logic [MODE_N-1:0] ROLL_AWAY_MODES_DEF = 8'hFF;
    localparam logic [MODE_N-1:0] LEVER_SUP_MODES_DEF = 8'hFE;
    localparam logic [MODE_N-1:0] FWD_ONLY_MODES_DEF = 8'h3E;
    localparam logic [MODE_W-1:0] REV_SHUNT_MODE_DEF = 3'h7;

    // direction lever encoding
    localparam logic [1:0] LEVER_NEUTRAL = 2'h0;
    localparam logic [1:0] LEVER_FWD = 2'h1;
    localparam logic [1:0] LEVER_REV = 2'h2;

    // distance accumulator indexes
    localparam int ACC_STILL_CREEP = 0;
    localparam int ACC_NEUTRAL_ROLL = 1;
    localparam int ACC_ROLL_BACK = 2;
    localparam int ACC_ROLL_FWD = 3;
    localparam int ACC_FWD_ONLY = 4;
    localparam int ACC_REV_SHUNT = 5;
    localparam int ACC_N = 6;

    // reset value of every error flag
    localparam logic ERR_RESET = 1'b0;

    // sticky supervision errors handed to error management
    typedef struct packed {
        logic roll_away;              // vital
        logic roll_back;              // vital
        logic roll_forward;           // vital
        logic direction_mode;         // vital
        logic lever_travel_mismatch_error; // non-vital while moving
        logic mismatch_fatal;         // fatal once standstill reached
    } tms_err_t;

endpackage : tms_pkg

// file: tms_sync.sv
// two-flop synchroniser for a group of asynchronous level inputs
// assumes nothing reads the first stage except the second stage
`timescale 1ns/1ps
module tms_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta; // first stage, read only by the second

    // one pair of flops per bit
    genvar b;
    for (b = 0; b < W; b++)
    begin : g_bit
        always_ff @(posedge ref_clk_i)
        begin
            if (rst_i)
            begin
                meta[b] <= 1'b0;
                sync_o[b] <= 1'b0;
            end
            else
            begin
                meta[b] <= async_i[b];
                sync_o[b] <= meta[b];
            end
        end
    end

endmodule : tms_sync

// file: tms_supervisor.sv
// train movement supervision: roll-away, direction lever and mode direction
// assumes odometry pulses, standstill, lever and mode arrive from pins
// How it works
// - roll-away supervision only in its marked modes
// - creep over 20 m under standstill: roll-away
// - lever neutral, moving, over 5 m: roll-away
// - lever supervision only in its marked modes
// - lever forward, backward over 5 m: roll-back
// - lever reverse, forward over 5 m: roll-forward
// - lever against travel while moving: non-vital mismatch
// - mismatch turns fatal on reaching standstill
// - backward protection only in forward-only modes
// - forward-only mode, lever reverse, backward 5 m: error
// - reverse shunting, lever forward, forward 5 m: error
// - vital or fatal errors demand emergency brake
`timescale 1ns/1ps
module tms_supervisor #(
    parameter int ODO_STEP_CM = tms_pkg::ODO_STEP_CM_DEF,
    parameter int CNT_W = tms_pkg::CNT_W_DEF,
    parameter logic [tms_pkg::MODE_N-1:0] ROLL_AWAY_MODES =
        tms_pkg::ROLL_AWAY_MODES_DEF,
    parameter logic [tms_pkg::MODE_N-1:0] LEVER_SUP_MODES =
        tms_pkg::LEVER_SUP_MODES_DEF,
    parameter logic [tms_pkg::MODE_N-1:0] FWD_ONLY_MODES =
        tms_pkg::FWD_ONLY_MODES_DEF,
    parameter logic [tms_pkg::MODE_W-1:0] REV_SHUNT_MODE =
        tms_pkg::REV_SHUNT_MODE_DEF
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // odometry: one pulse per travel step, direction high for forward
    input wire logic odo_step_i,
    input wire logic odo_fwd_i,
    // standstill condition from odometry
    input wire logic standstill_i,
    // direction lever of the active cab and current operating mode
    input wire logic [1:0] lever_i,
    input wire logic [tms_pkg::MODE_W-1:0] mode_i,
    // error management acknowledges and clears raised errors
    input wire logic err_ack_i,
    // raised errors and the brake demand
    output tms_pkg::tms_err_t errors_o,
    output logic eb_demand_o,
    // supervision functions currently active
    output logic roll_away_active_o,
    output logic lever_sup_active_o,
    output logic reverse_prot_active_o,
    output logic forward_prot_active_o
);

    // thresholds expressed as odometry steps; an error needs strictly more
    localparam int STILL_STEPS = tms_pkg::ROLL_AWAY_STILL_CM / ODO_STEP_CM;
    localparam int TRAVEL_STEPS = tms_pkg::TRAVEL_LIMIT_CM / ODO_STEP_CM;

    // refuse a step or counter width the thresholds cannot live with
    if (ODO_STEP_CM < 1 || ODO_STEP_CM > tms_pkg::TRAVEL_LIMIT_CM)
    begin : g_bad_step
        $error("odometry step length out of range");
    end
    if (CNT_W < 2 || CNT_W > 24 || STILL_STEPS + 1 >= (1 << CNT_W))
    begin : g_bad_width
        $error("distance counter too narrow for the thresholds");
    end

    // synchronised pin levels
    // step, direction, standstill, two lever bits and the mode code
    localparam int SYNC_W = 5 + tms_pkg::MODE_W;
    logic [SYNC_W-1:0] sync_bus;
    logic step_s; // odometry step level
    logic fwd_s; // odometry direction
    logic still_s; // standstill condition
    logic [1:0] lever_s; // lever position
    logic [tms_pkg::MODE_W-1:0] mode_s; // operating mode

    // every odometry, standstill, lever and mode pin passes two flops before any logic sees it
    tms_sync #(
        .W(SYNC_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i({odo_step_i, odo_fwd_i, standstill_i, lever_i, mode_i}),
        .sync_o(sync_bus)
    );

    assign {step_s, fwd_s, still_s, lever_s, mode_s} = sync_bus;

    // delayed copies for edge and change detection
    logic step_q; // previous step level
    logic still_q; // previous standstill
    logic [1:0] lever_q; // previous lever position

    // history flops, taken from the synchronised side only
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            step_q <= 1'b0;
            still_q <= 1'b1;
            lever_q <= tms_pkg::LEVER_NEUTRAL;
        end
        else
        begin
            step_q <= step_s;
            still_q <= still_s;
            lever_q <= lever_s;
        end
    end

    // the synchroniser wakes from reset at zero, so a train already at
    // standstill would look as if it had just regained it; the regain
    // event is held off until every stage carries a real pin level
    logic [2:0] warm; // one bit per stage filled since release

    // a one walks up the chain, one stage per clock after release
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            warm <= '0;
        end
        else
        begin
            warm <= {warm[1:0], 1'b1};
        end
    end

    // decoded events and conditions
    logic step; // one travel step completed
    logic still_rise; // standstill just regained
    logic lever_chg; // lever moved this cycle
    logic lev_fwd; // lever at forward
    logic lev_rev; // lever at reverse
    logic lev_neu; // lever neither forward nor reverse
    logic ra_en; // roll-away supervision enabled
    logic dc_en; // lever supervision enabled
    logic rm_en; // backward-movement protection enabled
    logic fm_en; // forward-movement protection enabled

    assign step = step_s & ~step_q;
    // masked while the stages still hold their reset zeros
    assign still_rise = still_s & ~still_q & warm[2];
    assign lever_chg = lever_s != lever_q;
    assign lev_fwd = lever_s == tms_pkg::LEVER_FWD;
    assign lev_rev = lever_s == tms_pkg::LEVER_REV;
    // the unused code 2'h3 counts as neither position, the safe reading
    assign lev_neu = ~lev_fwd & ~lev_rev;
    assign ra_en = ROLL_AWAY_MODES[mode_s];
    assign dc_en = LEVER_SUP_MODES[mode_s];
    assign rm_en = FWD_ONLY_MODES[mode_s];
    assign fm_en = mode_s == REV_SHUNT_MODE;

    // per-accumulator step and clear conditions, with their thresholds
    logic [tms_pkg::ACC_N-1:0] acc_inc;
    logic [tms_pkg::ACC_N-1:0] acc_clr;
    logic [tms_pkg::ACC_N-1:0] acc_over;
    logic [tms_pkg::ACC_N-1:0] acc_hit; // this step takes the count past
    logic [CNT_W-1:0] acc_limit [tms_pkg::ACC_N];

    // which travel feeds each accumulator and what restarts it
    always_comb
    begin
        // creep under standstill, any direction
        acc_inc[tms_pkg::ACC_STILL_CREEP] = step & still_s;
        acc_clr[tms_pkg::ACC_STILL_CREEP] = ~still_s | ~ra_en;
        // neutral lever after standstill lost, any direction
        acc_inc[tms_pkg::ACC_NEUTRAL_ROLL] = step & ~still_s & lev_neu;
        acc_clr[tms_pkg::ACC_NEUTRAL_ROLL] = still_s | ~lev_neu | ~ra_en;
        // lever forward, backward travel
        acc_inc[tms_pkg::ACC_ROLL_BACK] = step & ~fwd_s & lev_fwd;
        acc_clr[tms_pkg::ACC_ROLL_BACK] = still_rise | lever_chg | ~dc_en;
        // lever reverse, forward travel
        acc_inc[tms_pkg::ACC_ROLL_FWD] = step & fwd_s & lev_rev;
        acc_clr[tms_pkg::ACC_ROLL_FWD] = still_rise | lever_chg | ~dc_en;
        // forward-only mode, lever reverse, backward travel
        acc_inc[tms_pkg::ACC_FWD_ONLY] = step & ~fwd_s & lev_rev;
        acc_clr[tms_pkg::ACC_FWD_ONLY] = still_rise | lever_chg | ~rm_en;
        // reverse shunting, lever forward, forward travel
        acc_inc[tms_pkg::ACC_REV_SHUNT] = step & fwd_s & lev_fwd;
        acc_clr[tms_pkg::ACC_REV_SHUNT] = still_rise | lever_chg | ~fm_en;
    end

    // one saturating distance counter per check
    genvar a;
    for (a = 0; a < tms_pkg::ACC_N; a++)
    begin : g_acc
        logic [CNT_W-1:0] cnt; // travel steps since the start condition

        // only the standstill creep check uses the 20 m figure
        assign acc_limit[a] = (a == tms_pkg::ACC_STILL_CREEP) ?
            CNT_W'(STILL_STEPS) : CNT_W'(TRAVEL_STEPS);
        assign acc_over[a] = cnt > acc_limit[a];
        // raise only on the crossing step, so an acknowledge can clear the
        // flag while the counter still sits saturated past the limit
        assign acc_hit[a] = acc_inc[a] & ~acc_clr[a] & (cnt == acc_limit[a]);

        // clear wins: a restarted check must measure from zero
        always_ff @(posedge ref_clk_i)
        begin
            if (rst_i)
            begin
                cnt <= '0;
            end
            else if (acc_clr[a])
            begin
                cnt <= '0;
            end
            else if (acc_inc[a] && !acc_over[a])
            begin
                // holding just past the limit keeps the counter from wrapping
                cnt <= cnt + CNT_W'(1);
            end
        end
    end

    // set terms for each sticky error
    logic set_roll_away;
    logic set_roll_back;
    logic set_roll_fwd;
    logic set_dir_mode;
    logic set_mismatch;
    logic set_fatal;

    assign set_roll_away = acc_hit[tms_pkg::ACC_STILL_CREEP] & still_s
        | acc_hit[tms_pkg::ACC_NEUTRAL_ROLL];
    assign set_roll_back = acc_hit[tms_pkg::ACC_ROLL_BACK];
    assign set_roll_fwd = acc_hit[tms_pkg::ACC_ROLL_FWD];
    assign set_dir_mode = acc_hit[tms_pkg::ACC_FWD_ONLY]
        | acc_hit[tms_pkg::ACC_REV_SHUNT];
    // judged per step, so direction always comes from fresh odometry
    assign set_mismatch = dc_en & step & ~still_s
        & (lev_fwd & ~fwd_s | lev_rev & fwd_s);
    assign set_fatal = still_rise & errors_o.lever_travel_mismatch_error;

    // vital errors: held until acknowledged, a new set beats the ack
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            errors_o.roll_away <= tms_pkg::ERR_RESET;
            errors_o.roll_back <= tms_pkg::ERR_RESET;
            errors_o.roll_forward <= tms_pkg::ERR_RESET;
            errors_o.direction_mode <= tms_pkg::ERR_RESET;
        end
        else
        begin
            errors_o.roll_away <= set_roll_away
                | errors_o.roll_away & ~err_ack_i;
            errors_o.roll_back <= set_roll_back
                | errors_o.roll_back & ~err_ack_i;
            errors_o.roll_forward <= set_roll_fwd
                | errors_o.roll_forward & ~err_ack_i;
            errors_o.direction_mode <= set_dir_mode
                | errors_o.direction_mode & ~err_ack_i;
        end
    end

    // lever mismatch: non-vital while moving, escalated at standstill
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            errors_o.lever_travel_mismatch_error <= tms_pkg::ERR_RESET;
            errors_o.mismatch_fatal <= tms_pkg::ERR_RESET;
        end
        else
        begin
            // stays raised through the stop so the fatal flag can follow it
            errors_o.lever_travel_mismatch_error <= set_mismatch
                | errors_o.lever_travel_mismatch_error & ~err_ack_i;
            errors_o.mismatch_fatal <= set_fatal
                | errors_o.mismatch_fatal & ~err_ack_i;
        end
    end

    // brake demand follows every vital or fatal flag, never the non-vital one
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            eb_demand_o <= 1'b0;
        end
        else
        begin
            // taken from the set terms too, so the demand is not a cycle late
            eb_demand_o <= set_roll_away | set_roll_back | set_roll_fwd
                | set_dir_mode | set_fatal
                | errors_o.roll_away | errors_o.roll_back
                | errors_o.roll_forward | errors_o.direction_mode
                | errors_o.mismatch_fatal;
        end
    end

    // which functions are supervising now, registered for display
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            roll_away_active_o <= 1'b0;
            lever_sup_active_o <= 1'b0;
            reverse_prot_active_o <= 1'b0;
            forward_prot_active_o <= 1'b0;
        end
        else
        begin
            roll_away_active_o <= ra_en;
            lever_sup_active_o <= dc_en;
            reverse_prot_active_o <= rm_en;
            forward_prot_active_o <= fm_en;
        end
    end

endmodule : tms_supervisor

// file: tms_supervisor_properties.sv
// checker for the movement supervisor: brake demand, gating, sticky flags
// assumes it is bound to tms_supervisor and sees only its ports
`timescale 1ns/1ps
module tms_supervisor_properties #(
    parameter logic [7:0] RA_M = 8'hFF,
    parameter logic [7:0] LV_M = 8'hFE,
    parameter logic [7:0] FO_M = 8'h3E,
    parameter logic [2:0] RS_M = 3'h7
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic [2:0] mode_i,
    input wire logic err_ack_i,
    // watched outputs
    input wire tms_pkg::tms_err_t errors_o,
    input wire logic eb_demand_o,
    input wire logic roll_away_active_o,
    input wire logic lever_sup_active_o,
    input wire logic reverse_prot_active_o,
    input wire logic forward_prot_active_o
);
    // any flag that must brake the train
    logic vit;
    assign vit = errors_o.roll_away | errors_o.roll_back |
        errors_o.roll_forward | errors_o.direction_mode |
        errors_o.mismatch_fatal;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // mode held long enough to pass the synchroniser and register
    sequence s_mode_quiet;
        $stable(mode_i) [*6];
    endsequence
    property p_mode(logic act, logic en);
        s_mode_quiet |-> act == en;
    endproperty
    AST_EB_VITAL: assert property (vit |-> eb_demand_o)
        else $error("vital flag without brake demand");
    AST_EB_QUIET: assert property (!vit && !$past(vit) |-> !eb_demand_o)
        else $error("brake demand without vital flag");
    AST_FATAL_SRC: assert property ($rose(errors_o.mismatch_fatal) |->
        $past(errors_o.lever_travel_mismatch_error))
        else $error("fatal mismatch without prior mismatch");
    AST_RA_GATE: assert property ($rose(errors_o.roll_away) |->
        roll_away_active_o || $past(roll_away_active_o))
        else $error("roll-away raised while disabled");
    AST_MIS_GATE: assert property (
        $rose(errors_o.lever_travel_mismatch_error) |->
        lever_sup_active_o || $past(lever_sup_active_o))
        else $error("mismatch raised while lever check disabled");
    AST_RA_MODE: assert property (p_mode(roll_away_active_o, RA_M[mode_i]))
        else $error("roll-away enable wrong for mode");
    AST_LV_MODE: assert property (p_mode(lever_sup_active_o, LV_M[mode_i]))
        else $error("lever check enable wrong for mode");
    AST_RV_MODE: assert property (
        p_mode(reverse_prot_active_o, FO_M[mode_i]))
        else $error("backward protection wrong for mode");
    AST_FW_MODE: assert property (
        p_mode(forward_prot_active_o, mode_i == RS_M))
        else $error("forward protection wrong for mode");
    AST_HOLD: assert property (|($past(errors_o) & ~errors_o) |->
        $past(err_ack_i))
        else $error("flag dropped without acknowledge");
endmodule : tms_supervisor_properties
bind tms_supervisor tms_supervisor_properties #(.RA_M(ROLL_AWAY_MODES),
    .LV_M(LEVER_SUP_MODES), .FO_M(FWD_ONLY_MODES), .RS_M(REV_SHUNT_MODE))
    tms_supervisor_properties_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .mode_i(mode_i), .err_ack_i(err_ack_i), .errors_o(errors_o),
    .eb_demand_o(eb_demand_o), .roll_away_active_o(roll_away_active_o),
    .lever_sup_active_o(lever_sup_active_o),
    .reverse_prot_active_o(reverse_prot_active_o),
    .forward_prot_active_o(forward_prot_active_o));

// file: tms_odo_model.sv
// odometry sensor model: a train of step pulses in one direction
// assumes the bench asks for a burst only while busy_o is low
`timescale 1ns/1ps
module tms_odo_model (
    // clock
    input wire logic ref_clk_i,
    // burst request
    input wire logic start_i,
    input wire logic fwd_i,
    input wire logic [7:0] count_i,
    // sensor pins and burst status
    output logic odo_step_o = 1'b0,
    output logic odo_fwd_o = 1'b0,
    output logic busy_o = 1'b0
);
    logic [7:0] left = 8'h00; // pulses still to send
    logic [2:0] ph = 3'h0; // phase within one pulse
    // three low then three high cycles, wider than the synchroniser needs
    always @(posedge ref_clk_i)
    begin
        if (start_i && !busy_o)
        begin
            left <= count_i;
            ph <= 3'h0;
            busy_o <= 1'b1;
            odo_fwd_o <= fwd_i; // direction settles before the first edge
        end
        else if (busy_o)
        begin
            ph <= ph + 3'h1;
            if (ph == 3'h2)
                odo_step_o <= 1'b1;
            if (ph == 3'h5)
            begin
                odo_step_o <= 1'b0;
                ph <= 3'h0;
                left <= left - 8'h01;
                if (left == 8'h01)
                    busy_o <= 1'b0;
            end
        end
    end
endmodule : tms_odo_model

// file: train_movement_supervision_test.sv
// bench for the movement supervisor with a step of 1 m (limits 20 and 5)
// assumes the odometry model and the bound checker are compiled with it
`timescale 1ns/1ps
module train_movement_supervision_test;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, standstill_i = 1'b1;
    logic err_ack_i = 1'b0, start = 1'b0, sfwd = 1'b0;
    logic [1:0] lever_i = tms_pkg::LEVER_NEUTRAL;
    logic [2:0] mode_i = 3'h1; // forward-only mode
    logic [7:0] cnt = 8'h00;
    logic odo_step, odo_fwd, busy, eb, ra_act, lv_act, rv_act, fw_act;
    tms_pkg::tms_err_t errors_o;
    logic [5:0] ev; // flags as a vector, roll_away at the top
    int n_mismatch = 0, checks_done = 0;
    assign ev = errors_o;
    tms_odo_model tms_odo_model_i (.ref_clk_i(ref_clk_i), .start_i(start),
        .fwd_i(sfwd), .count_i(cnt), .odo_step_o(odo_step),
        .odo_fwd_o(odo_fwd), .busy_o(busy));
    tms_supervisor #(.ODO_STEP_CM(100)) tms_supervisor_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .odo_step_i(odo_step),
        .odo_fwd_i(odo_fwd), .standstill_i(standstill_i), .lever_i(lever_i),
        .mode_i(mode_i), .err_ack_i(err_ack_i), .errors_o(errors_o),
        .eb_demand_o(eb), .roll_away_active_o(ra_act),
        .lever_sup_active_o(lv_act), .reverse_prot_active_o(rv_act),
        .forward_prot_active_o(fw_act));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    task stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    task chk(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %b expected %b", $time, got, exp);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : wt
    // one burst of steps, then time for the flags to settle
    task steps(input int n, input logic f);
        int k;
        @(posedge ref_clk_i);
        start <= 1'b1;
        sfwd <= f;
        cnt <= n[7:0];
        wt(2);
        start <= 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 1000)
        begin
            @(posedge ref_clk_i);
            k++;
        end
        if (k == 1000)
        begin
            n_mismatch++;
            $display("[ERR] %0t step burst never ended", $time);
            stop_test();
        end
        wt(8);
    endtask : steps
    // drop and regain standstill so counters restart, setting lever and mode on the regain
    task prep(input logic [1:0] lev, input logic [2:0] md, input logic st);
        standstill_i <= 1'b0;
        wt(6);
        lever_i <= lev;
        mode_i <= md;
        standstill_i <= 1'b1;
        wt(6);
        standstill_i <= st;
        wt(6);
    endtask : prep
    task ack;
        err_ack_i <= 1'b1;
        @(posedge ref_clk_i);
        err_ack_i <= 1'b0;
        wt(4);
        chk(|ev, 1'b0);
        chk(eb, 1'b0);
    endtask : ack
    // at the limit nothing, one step past it the flag and the brake
    task run(input int n, input logic f, input int b);
        steps(n, f);
        chk(ev[b], 1'b0);
        chk(eb, 1'b0);
        steps(1, f);
        chk(ev[b], 1'b1);
        chk(eb, 1'b1);
        ack();
    endtask : run
    initial
    begin
        wt(12);
        chk(|ev, 1'b0);
        chk(eb, 1'b0);
        rst_i <= 1'b0;
        wt(4);
        // creep at standstill, both directions add up
        prep(tms_pkg::LEVER_NEUTRAL, 3'h1, 1'b1);
        steps(10, 1'b1);
        run(10, 1'b0, 5);
        // neutral rolling, standstill regained midway restarts the count
        prep(tms_pkg::LEVER_NEUTRAL, 3'h1, 1'b0);
        steps(5, 1'b1);
        standstill_i <= 1'b1;
        wt(6);
        standstill_i <= 1'b0;
        wt(6);
        run(5, 1'b0, 5);
        prep(tms_pkg::LEVER_FWD, 3'h1, 1'b0);
        run(5, 1'b0, 4);
        prep(tms_pkg::LEVER_REV, 3'h1, 1'b0);
        run(5, 1'b1, 3);
        chk(rv_act, 1'b1);
        run(5, 1'b0, 2);
        prep(tms_pkg::LEVER_FWD, 3'h7, 1'b0);
        chk(fw_act, 1'b1);
        run(5, 1'b1, 2);
        // mode without lever or backward checks stays silent
        prep(tms_pkg::LEVER_REV, 3'h0, 1'b0);
        steps(6, 1'b0);
        chk(|ev, 1'b0);
        chk(lv_act, 1'b0);
        // lever against travel: no brake until the train stops
        prep(tms_pkg::LEVER_FWD, 3'h1, 1'b0);
        steps(1, 1'b0);
        chk(ev[1], 1'b1);
        chk(eb, 1'b0);
        standstill_i <= 1'b1;
        wt(8);
        chk(ev[0], 1'b1);
        chk(eb, 1'b1);
        ack();
        stop_test();
    end
endmodule : train_movement_supervision_test
